// File: core/tap_pkg.sv
// constants, types and states of the boundary-scan test port
// assumes a single system clock samples every test pin
package tap_pkg;
	localparam int IR_LEN = 10;
	localparam int SIG_LEN = 16;
	localparam int UCODE_LEN = 32;
	localparam int ID_LEN = 32;
	localparam int BSR_LEN_DEF = 96;
	localparam int ID_VER_W = 4;
	localparam int ID_PART_W = 16;
	localparam int ID_MAKER_W = 11;
	localparam int TMS_RESET_RISES = 5;
	typedef logic [IR_LEN-1:0] instr_t;
	typedef logic [SIG_LEN-1:0] signature_t;
	typedef logic [UCODE_LEN-1:0] usercode_t;
	typedef logic [ID_LEN-1:0] idword_t;
	localparam instr_t IR_CAPTURE = 10'h001;
	localparam instr_t OP_BYPASS_DEF = 10'h3ff;
	localparam instr_t OP_EXTEST_DEF = 10'h000;
	localparam instr_t OP_SAMPLE_DEF = 10'h055;
	localparam instr_t OP_IDCODE_DEF = 10'h059;
	localparam instr_t OP_USERCODE_DEF = 10'h079;
	localparam instr_t OP_SIG_DEF = 10'h007;
	// identity values below are arbitrary
	localparam logic [ID_VER_W-1:0] ID_VER_DEF = 4'h2;
	localparam logic [ID_PART_W-1:0] ID_PART_DEF = 16'h1234;
	localparam logic [ID_MAKER_W-1:0] ID_MAKER_DEF = 11'h155;
	localparam logic ID_FIXED_BIT = 1'b1;
	typedef enum logic [15:0] {
		st_reset = 16'h0001,
		st_idle = 16'h0002,
		st_sel_dr = 16'h0004,
		st_cap_dr = 16'h0008,
		st_shift_dr = 16'h0010,
		st_exit1_dr = 16'h0020,
		st_pause_dr = 16'h0040,
		st_exit2_dr = 16'h0080,
		st_upd_dr = 16'h0100,
		st_sel_ir = 16'h0200,
		st_cap_ir = 16'h0400,
		st_shift_ir = 16'h0800,
		st_exit1_ir = 16'h1000,
		st_pause_ir = 16'h2000,
		st_exit2_ir = 16'h4000,
		st_upd_ir = 16'h8000
	} tap_state_t;
endpackage

// File: core/chain_if.sv
// carrier between the port controller and its boundary-scan chain
// assumes both ends run on clk_sys
`timescale 1ns/10ps
interface chain_if #(parameter int LEN = 96);
	logic capture;
	logic shift;
	logic update;
	logic si;
	logic so;
	logic [LEN-1:0] pin_in;
	logic [LEN-1:0] pin_out;
	modport ctrl (output capture, shift, update, si, pin_in, input so, pin_out);
	modport chain (input capture, shift, update, si, pin_in, output so, pin_out);
endinterface

// File: core/scan_chain.sv
// boundary-scan cell chain: capture, shift toward bit 0, update latch
// assumes strobes are single clk_sys pulses from the controller
`timescale 1ns/10ps
module scan_chain #(
	parameter int LEN = 96
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// controller side
	chain_if.chain bus
);
	import tap_pkg::*;
	logic [LEN-1:0] sr_q;
	logic [LEN-1:0] upd_q;
	// ********************
	// per-cell capture, shift and update
	// ********************
	genvar i;
	generate
		for (i = 0; i < LEN; i++) begin : g_cell
			logic shift_in;
			if (i == LEN-1) begin : g_top
				assign shift_in = bus.si;
			end else begin : g_mid
				assign shift_in = sr_q[i+1];
			end
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					sr_q[i] <= 1'b0;
				end else if (bus.capture) begin
					sr_q[i] <= bus.pin_in[i];
				end else if (bus.shift) begin
					sr_q[i] <= shift_in;
				end
			end
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					upd_q[i] <= 1'b0;
				end else if (bus.update) begin
					upd_q[i] <= sr_q[i];
				end
			end
		end
	endgenerate
	assign bus.so = sr_q[0];
	assign bus.pin_out = upd_q;
	a_chain_update: assert property (@(posedge clk_sys) disable iff (!rst_b)
		bus.update |=> upd_q == $past(sr_q))
		else $error("chain update latch did not copy shift stage");
endmodule

// File: core/boundary_scan_test_port.sv
// boundary-scan test access port with instruction, id, user code,
// signature, bypass and boundary registers
// assumes test pins are asynchronous and much slower than clk_sys
//
// Behaviour
// - four-wire boundary-scan test port per the 1149.1 standard.
// - instruction register is ten bits; tester shifts exactly ten.
// - sixteen-bit user signature register sits between data in and out.
// - thirty-two-bit user code register shifts out the programmed value.
// - boundary chain length is a per-variant parameter, e.g. 96, 288, 624.
// - id word is version, part number, maker identity, fixed bit, MSB first.
// - id word bit zero always reads one.
// - with the port disabled its four pins serve as user pins.
`timescale 1ns/10ps
module boundary_scan_test_port #(
	parameter int BSR_LEN = tap_pkg::BSR_LEN_DEF,
	parameter tap_pkg::instr_t OP_BYPASS = tap_pkg::OP_BYPASS_DEF,
	parameter tap_pkg::instr_t OP_EXTEST = tap_pkg::OP_EXTEST_DEF,
	parameter tap_pkg::instr_t OP_SAMPLE = tap_pkg::OP_SAMPLE_DEF,
	parameter tap_pkg::instr_t OP_IDCODE = tap_pkg::OP_IDCODE_DEF,
	parameter tap_pkg::instr_t OP_USERCODE = tap_pkg::OP_USERCODE_DEF,
	parameter tap_pkg::instr_t OP_SIG = tap_pkg::OP_SIG_DEF,
	parameter logic [tap_pkg::ID_VER_W-1:0] ID_VER = tap_pkg::ID_VER_DEF,
	parameter logic [tap_pkg::ID_PART_W-1:0] ID_PART = tap_pkg::ID_PART_DEF,
	parameter logic [tap_pkg::ID_MAKER_W-1:0] ID_MAKER = tap_pkg::ID_MAKER_DEF
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// test pins
	input wire logic tck_pin,
	input wire logic tms_pin,
	input wire logic tdi_pin,
	input wire logic trst_b_pin,
	output logic tdo_o,
	output logic tdo_oe,
	// port mode and user use of the pins
	input wire logic scan_en,
	input wire logic user_tdo_d,
	input wire logic user_tdo_oe,
	output logic user_tck_q,
	output logic user_tms_q,
	output logic user_tdi_q,
	// programmed contents
	input wire tap_pkg::usercode_t user_code,
	input wire tap_pkg::signature_t user_signature,
	// boundary cells
	input wire logic [BSR_LEN-1:0] bsr_pin_in,
	output logic [BSR_LEN-1:0] bsr_pin_out,
	output logic extest_q
);
	import tap_pkg::*;
	localparam idword_t ID_WORD = {ID_VER, ID_PART, ID_MAKER, ID_FIXED_BIT};
	// ********************
	// pin synchronisers
	// ********************
	logic tck_s1_q, tck_s2_q, tck_s3_q, tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;
	logic trst_s1_q, trst_s2_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			{tck_s1_q, tck_s2_q, tck_s3_q} <= 3'h0;
			{tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q} <= 4'hf;
			{trst_s1_q, trst_s2_q} <= 2'h0;
		end else begin
			{tck_s1_q, tck_s2_q, tck_s3_q} <= {tck_pin, tck_s1_q, tck_s2_q};
			{tms_s1_q, tms_s2_q} <= {tms_pin, tms_s1_q};
			{tdi_s1_q, tdi_s2_q} <= {tdi_pin, tdi_s1_q};
			{trst_s1_q, trst_s2_q} <= {trst_b_pin, trst_s1_q};
		end
	end
	logic tck_rise, tck_fall, tap_clr;
	assign tck_rise = tck_s2_q & ~tck_s3_q & scan_en;
	assign tck_fall = ~tck_s2_q & tck_s3_q & scan_en;
	assign tap_clr = ~trst_s2_q | ~scan_en;
	// ********************
	// controller state machine
	// ********************
	tap_state_t state_q, state_d;
	always_comb begin
		state_d = state_q;
		case (state_q)
			st_reset: state_d = tms_s2_q ? st_reset : st_idle;
			st_idle: state_d = tms_s2_q ? st_sel_dr : st_idle;
			st_sel_dr: state_d = tms_s2_q ? st_sel_ir : st_cap_dr;
			st_cap_dr: state_d = tms_s2_q ? st_exit1_dr : st_shift_dr;
			st_shift_dr: state_d = tms_s2_q ? st_exit1_dr : st_shift_dr;
			st_exit1_dr: state_d = tms_s2_q ? st_upd_dr : st_pause_dr;
			st_pause_dr: state_d = tms_s2_q ? st_exit2_dr : st_pause_dr;
			st_exit2_dr: state_d = tms_s2_q ? st_upd_dr : st_shift_dr;
			st_upd_dr: state_d = tms_s2_q ? st_sel_dr : st_idle;
			st_sel_ir: state_d = tms_s2_q ? st_reset : st_cap_ir;
			st_cap_ir: state_d = tms_s2_q ? st_exit1_ir : st_shift_ir;
			st_shift_ir: state_d = tms_s2_q ? st_exit1_ir : st_shift_ir;
			st_exit1_ir: state_d = tms_s2_q ? st_upd_ir : st_pause_ir;
			st_pause_ir: state_d = tms_s2_q ? st_exit2_ir : st_pause_ir;
			st_exit2_ir: state_d = tms_s2_q ? st_upd_ir : st_shift_ir;
			st_upd_ir: state_d = tms_s2_q ? st_sel_dr : st_idle;
			default: state_d = st_reset;
		endcase
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= st_reset;
		end else if (tap_clr) begin
			state_q <= st_reset;
		end else if (tck_rise) begin
			state_q <= state_d;
		end
	end
	// ********************
	// instruction register
	// ********************
	instr_t ir_sr_q, ir_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ir_sr_q <= IR_CAPTURE;
		end else if (tck_rise && state_q == st_cap_ir) begin
			ir_sr_q <= IR_CAPTURE;
		end else if (tck_rise && state_q == st_shift_ir) begin
			ir_sr_q <= {tdi_s2_q, ir_sr_q[IR_LEN-1:1]};
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ir_q <= OP_IDCODE;
		end else if (tap_clr || (tck_rise && state_q == st_reset)) begin
			ir_q <= OP_IDCODE;
		end else if (tck_rise && state_q == st_upd_ir) begin
			ir_q <= ir_sr_q;
		end
	end
	// ********************
	// data register selection and shift
	// ********************
	logic sel_id, sel_uc, sel_sig, sel_bsr;
	assign sel_id = (ir_q == OP_IDCODE);
	assign sel_uc = (ir_q == OP_USERCODE);
	assign sel_sig = (ir_q == OP_SIG);
	assign sel_bsr = (ir_q == OP_EXTEST) || (ir_q == OP_SAMPLE);
	idword_t dr_sr_q, dr_sr_d;
	always_comb begin
		dr_sr_d = dr_sr_q >> 1;
		if (sel_id || sel_uc) begin
			dr_sr_d[ID_LEN-1] = tdi_s2_q;
		end else if (sel_sig) begin
			dr_sr_d[SIG_LEN-1] = tdi_s2_q;
		end else begin
			dr_sr_d[0] = tdi_s2_q; // bypass cell
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dr_sr_q <= '0;
		end else if (tck_rise && state_q == st_cap_dr) begin
			if (sel_id) begin
				dr_sr_q <= ID_WORD;
			end else if (sel_uc) begin
				dr_sr_q <= user_code;
			end else if (sel_sig) begin
				dr_sr_q <= {{(ID_LEN-SIG_LEN){1'b0}}, user_signature};
			end else begin
				dr_sr_q <= '0;
			end
		end else if (tck_rise && state_q == st_shift_dr) begin
			dr_sr_q <= dr_sr_d;
		end
	end
	// ********************
	// boundary chain
	// ********************
	chain_if #(.LEN(BSR_LEN)) chain_bus ();
	assign chain_bus.capture = tck_rise && state_q == st_cap_dr && sel_bsr;
	assign chain_bus.shift = tck_rise && state_q == st_shift_dr && sel_bsr;
	assign chain_bus.update = tck_rise && state_q == st_upd_dr && sel_bsr;
	assign chain_bus.si = tdi_s2_q;
	assign chain_bus.pin_in = bsr_pin_in;
	scan_chain #(.LEN(BSR_LEN)) u_chain (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.bus(chain_bus)
	);
	assign bsr_pin_out = chain_bus.pin_out;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			extest_q <= 1'b0;
		end else begin
			extest_q <= (ir_q == OP_EXTEST);
		end
	end
	// ********************
	// data out and user pins
	// ********************
	logic shift_any, dr_bit;
	assign shift_any = (state_q == st_shift_ir) || (state_q == st_shift_dr);
	assign dr_bit = sel_bsr ? chain_bus.so : dr_sr_q[0];
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tdo_o <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (!scan_en) begin
			tdo_o <= user_tdo_d;
			tdo_oe <= user_tdo_oe;
		end else if (tck_fall) begin
			tdo_o <= (state_q == st_shift_ir) ? ir_sr_q[0] : dr_bit;
			tdo_oe <= shift_any;
		end
	end
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			{user_tck_q, user_tms_q, user_tdi_q} <= 3'h0;
		end else begin
			{user_tck_q, user_tms_q, user_tdi_q} <= {tck_s2_q, tms_s2_q, tdi_s2_q};
		end
	end
	// ********************
	// checks
	// ********************
	int unsigned tms_run_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tms_run_q <= 0;
		end else if (tck_rise) begin
			tms_run_q <= tms_s2_q ? tms_run_q + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_cap_dr;
		tck_rise && state_q == st_cap_dr;
	endsequence
	sequence s_shift_dr;
		tck_rise && state_q == st_shift_dr;
	endsequence
	a_ir_capture_load: assert property (tck_rise && state_q == st_cap_ir |=> ir_sr_q == IR_CAPTURE)
		else $error("instruction capture pattern wrong");
	a_id_word_load: assert property (s_cap_dr and sel_id |=> dr_sr_q == ID_WORD)
		else $error("id word not loaded on capture");
	a_id_lsb_one: assert property (s_cap_dr and sel_id |=> dr_sr_q[0] == 1'b1)
		else $error("id word bit zero is not one");
	a_usercode_load: assert property (s_cap_dr and sel_uc |=> dr_sr_q == $past(user_code))
		else $error("user code not captured");
	a_sig_load: assert property (s_cap_dr and sel_sig |=> dr_sr_q[SIG_LEN-1:0] == $past(user_signature))
		else $error("user signature not captured");
	a_dr_shift_lsb: assert property (s_shift_dr and sel_uc
		|=> dr_sr_q == {$past(tdi_s2_q), $past(dr_sr_q[ID_LEN-1:1])})
		else $error("data register did not shift toward bit zero");
	a_tms_five_reset: assert property (tms_run_q >= TMS_RESET_RISES |-> state_q == st_reset)
		else $error("five high mode samples did not reset controller");
	a_tdo_on_fall: assert property (scan_en && $past(scan_en) && $changed(tdo_o) |-> $past(tck_fall))
		else $error("data out changed away from a falling test clock");
	a_user_pins: assert property (!scan_en |=> tdo_o == $past(user_tdo_d) && tdo_oe == $past(user_tdo_oe))
		else $error("disabled port did not pass user output");
	a_bypass_one_bit: assert property (s_shift_dr and ir_q == OP_BYPASS |=> dr_sr_q[0] == $past(tdi_s2_q))
		else $error("bypass cell did not take data in");
endmodule

// File: test/tester_model.sv
// external test controller model driving the four test pins
// assumes clk_sys is the bench clock; test clock period is 8 clk_sys
`timescale 1ns/10ps
module tester_model (
	// clock
	input wire logic clk_sys,
	// test pins toward the port
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_b,
	// answer from the port
	input wire logic tdo_o,
	input wire logic tdo_oe
);
	// ****************************************
	// one test clock period
	// ****************************************
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		trst_b = 1'b1;
	end
	// fall with new mode and data, rise, then read data out
	task automatic step(input logic m, input logic d, output logic q);
		@(posedge clk_sys);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk_sys);
		tck <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		q = tdo_oe ? tdo_o : 1'bz;
	endtask
	// ****************************************
	// state walks and register scans
	// ****************************************
	// five rises with mode high, then to idle
	task automatic go_reset();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	// from idle: scan n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [639:0] din,
		output logic [639:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir) begin
			step(1'b1, 1'b0, q);
		end
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	task automatic trst_pulse();
		@(posedge clk_sys);
		trst_b <= 1'b0;
		repeat (4) @(posedge clk_sys);
		trst_b <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
endmodule

// File: test/boundary_scan_test_port_tb.sv
// self-checking bench of the boundary-scan test port
// assumes tester_model drives the test pins
`timescale 1ns/10ps
module boundary_scan_test_port_tb;
	import tap_pkg::*;
	localparam int BSR = 96;
	localparam logic [BSR-1:0] PAT_A = 96'h0123_4567_89ab_cdef_f0e1_d2c3;
	localparam logic [BSR-1:0] PAT_B = 96'h8000_a5a5_3c3c_0f0f_5555_0001;
	logic clk_sys, rst_b, scan_en, user_tdo_d, user_tdo_oe, q;
	logic tck, tms, tdi, trst_b, tdo_o, tdo_oe, extest_q;
	logic user_tck_q, user_tms_q, user_tdi_q;
	usercode_t user_code;
	signature_t user_signature;
	logic [BSR-1:0] bsr_pin_in, bsr_pin_out;
	logic [639:0] dout;
	int fail_count, compares;
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
	// ****************************************
	// clock, design and partner
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	boundary_scan_test_port #(.BSR_LEN(BSR)) uut (.clk_sys(clk_sys), .rst_b(rst_b),
		.tck_pin(tck), .tms_pin(tms), .tdi_pin(tdi), .trst_b_pin(trst_b), .tdo_o(tdo_o),
		.tdo_oe(tdo_oe), .scan_en(scan_en), .user_tdo_d(user_tdo_d),
		.user_tdo_oe(user_tdo_oe), .user_tck_q(user_tck_q), .user_tms_q(user_tms_q),
		.user_tdi_q(user_tdi_q), .user_code(user_code), .user_signature(user_signature),
		.bsr_pin_in(bsr_pin_in), .bsr_pin_out(bsr_pin_out), .extest_q(extest_q));
	tester_model tm (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe));
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_idcode();
		tm.go_reset();
		tm.scan(1'b0, 32, '0, dout);
		`CHK("idcode", {ID_VER_DEF, ID_PART_DEF, ID_MAKER_DEF, ID_FIXED_BIT}, dout[31:0])
		`CHK("id_lsb", 1'b1, dout[0])
	endtask
	task automatic t_usercode();
		tm.scan(1'b1, 10, 640'(OP_USERCODE_DEF), dout);
		`CHK("ir_capture", IR_CAPTURE, dout[9:0])
		tm.scan(1'b0, 32, '0, dout);
		`CHK("usercode", user_code, dout[31:0])
	endtask
	task automatic t_signature();
		tm.scan(1'b1, 10, 640'(OP_SIG_DEF), dout);
		tm.scan(1'b0, 32, 640'(32'h0000_a5c3), dout);
		`CHK("signature", user_signature, dout[15:0])
		`CHK("sig_through", 16'ha5c3, dout[31:16])
	endtask
	task automatic t_bypass();
		tm.scan(1'b1, 10, 640'(OP_BYPASS_DEF), dout);
		tm.scan(1'b0, 8, 640'(8'h5a), dout);
		`CHK("bypass", 8'hb4, dout[7:0])
	endtask
	task automatic t_boundary();
		tm.scan(1'b1, 10, 640'(OP_SAMPLE_DEF), dout);
		tm.scan(1'b0, BSR, '0, dout);
		`CHK("sample", PAT_A, dout[BSR-1:0])
		tm.scan(1'b1, 10, 640'(OP_EXTEST_DEF), dout);
		@(posedge clk_sys);
		#1;
		`CHK("extest_on", 1'b1, extest_q)
		tm.scan(1'b0, BSR, 640'(PAT_B), dout);
		`CHK("extest_cap", PAT_A, dout[BSR-1:0])
		`CHK("update", PAT_B, bsr_pin_out)
		tm.go_reset();
		`CHK("extest_off", 1'b0, extest_q)
	endtask
	task automatic t_user_pins();
		tm.scan(1'b1, 10, 640'(OP_USERCODE_DEF), dout);
		@(posedge clk_sys);
		scan_en <= 1'b0;
		user_tdo_d <= 1'b1;
		user_tdo_oe <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("user_tdo", 2'b11, {tdo_o, tdo_oe})
		`CHK("user_idle", 3'b100, {user_tck_q, user_tms_q, user_tdi_q})
		tm.step(1'b1, 1'b1, q);
		repeat (3) @(posedge clk_sys);
		#1;
		`CHK("user_in", 3'b111, {user_tck_q, user_tms_q, user_tdi_q})
		@(posedge clk_sys);
		scan_en <= 1'b1;
		repeat (3) @(posedge clk_sys);
		tm.step(1'b0, 1'b0, q);
		tm.scan(1'b0, 32, '0, dout);
		`CHK("back_id", {ID_VER_DEF, ID_PART_DEF, ID_MAKER_DEF, ID_FIXED_BIT}, dout[31:0])
		tm.scan(1'b1, 10, 640'(OP_USERCODE_DEF), dout);
		tm.trst_pulse();
		tm.step(1'b0, 1'b0, q);
		tm.scan(1'b0, 32, '0, dout);
		`CHK("trst_id", {ID_VER_DEF, ID_PART_DEF, ID_MAKER_DEF, ID_FIXED_BIT}, dout[31:0])
	endtask
	// ****************************************
	// verdict, watchdog and main sequence
	// ****************************************
	task automatic end_sim();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		$display("[ERR] watchdog exp done got hang");
		end_sim();
	end
	initial begin
		rst_b = 1'b0;
		scan_en = 1'b1;
		user_tdo_d = 1'b0;
		user_tdo_oe = 1'b0;
		user_code = 32'h89ab_cdef;
		user_signature = 16'h3e71;
		bsr_pin_in = PAT_A;
		repeat (3) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_idcode();
		t_usercode();
		t_signature();
		t_bypass();
		t_boundary();
		t_user_pins();
		end_sim();
	end
endmodule
